/* inc/rti_pkg.sv */
// Constants, opcodes, register map and decode for the transfer executor
`default_nettype none

package rti_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int DATA_W = 32;
   localparam int ADDR_W = 6;

   ////////////////////////////////////////////////////////////////////////////////
   // Register byte offsets, one aligned word each
   localparam logic [5:0] OFS_INSTR = 6'h00;   // Opcode issue, reads last opcode
   localparam logic [5:0] OFS_ACC = 6'h04;     // Accumulator
   localparam logic [5:0] OFS_REG_B = 6'h08;   // Upper holding register
   localparam logic [5:0] OFS_SERIAL = 6'h0C;  // Serial shift register
   localparam logic [5:0] OFS_POINTER = 6'h10; // Pointer register
   localparam logic [5:0] OFS_CONV = 6'h14;    // Converter control register
   localparam logic [5:0] OFS_IRQ1 = 6'h18;    // Interrupt control register one
   localparam logic [5:0] OFS_CMP = 6'h1C;     // Comparator value, read only
   localparam logic [5:0] OFS_STATUS = 6'h20;  // Carry and decode status

   ////////////////////////////////////////////////////////////////////////////////
   // Opcodes
   localparam logic [9:0] OPC_LOAD_SERIAL_PAIR = 10'h278;
   localparam logic [9:0] OPC_LOAD_POINTER = 10'h051;
   localparam logic [9:0] OPC_LOAD_COMPARE_VALUE = 10'h239;
   localparam logic [9:0] OPC_READ_IRQ_CTRL_ONE = 10'h253;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int CONVERTER_MODE_BIT = 3;
   localparam int STATUS_CARRY_BIT = 0;
   localparam int STATUS_UNKNOWN_BIT = 2;
   localparam logic [3:0] NIBBLE_RST = 4'h0;
   localparam logic [2:0] POINTER_RST = 3'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [9:0] OPCODE_RST = 10'h000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Decoded instruction kinds
   typedef enum logic [2:0] {
      OP_NONE,
      OP_LOAD_SERIAL_PAIR,
      OP_LOAD_POINTER,
      OP_LOAD_COMPARE_VALUE,
      OP_READ_IRQ_CTRL_ONE
   } rti_op_t;

   // Map a 10-bit instruction word onto its kind
   function automatic rti_op_t rti_decode(input logic [9:0] word);
      rti_op_t kind;
      kind = OP_NONE;
      unique case (word)
         OPC_LOAD_SERIAL_PAIR: kind = OP_LOAD_SERIAL_PAIR;
         OPC_LOAD_POINTER: kind = OP_LOAD_POINTER;
         OPC_LOAD_COMPARE_VALUE: kind = OP_LOAD_COMPARE_VALUE;
         OPC_READ_IRQ_CTRL_ONE: kind = OP_READ_IRQ_CTRL_ONE;
         default: kind = OP_NONE;
      endcase
      return kind;
   endfunction

endpackage

`default_nettype wire

/* sim/rti_exec_tb_top.sv */
// Self-checking testbench for the transfer instruction executor
`timescale 1ns/1ps
`default_nettype none

module rti_exec_tb_top
   import rti_pkg::*;
;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [ADDR_W-1:0] avs_address_i = 6'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [DATA_W-1:0] avs_writedata_i = 32'h0000_0000;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [DATA_W-1:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [3:0] acc_o;
   logic [3:0] reg_b_o;
   logic [7:0] compare_o;
   logic exec_o;
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;
   logic ex_q;
   logic [7:0] pat [2] = '{8'hA5, 8'h3C};

   ////////////////////////////////////////////////////////////
   // Device under test and 200 MHz clock
   rti_exec dut (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .acc_o(acc_o), .reg_b_o(reg_b_o), .compare_o(compare_o), .exec_o(exec_o)
   );

   always #2.5 clock_i = ~clock_i;

   ////////////////////////////////////////////////////////////
   // Compare, bus and report tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Hold the request until waitrequest is sampled low
   task automatic wait_ack();
      do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d,
                         input logic [3:0] b = 4'hF);
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= b;
      avs_write_i <= 1'b1;
      wait_ack();
      ex_q = exec_o;
      avs_write_i <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
      @(posedge clock_i);
      avs_address_i <= a;
      avs_read_i <= 1'b1;
      wait_ack();
      chk(what, exp, avs_readdata_o);
      avs_read_i <= 1'b0;
   endtask

   // Issue an opcode and expect the execute pulse
   task automatic op(input logic [9:0] opc);
      wr_reg(OFS_INSTR, {22'h0, opc});
      chk_bit("exec pulse", 1'b1, ex_q);
   endtask

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, error_cnt);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Cut a hang short
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         $display("timeout after %0d cycles", cycles);
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      repeat (16) @(posedge clock_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk_bit("idle waitrequest", 1'b1, avs_waitrequest_o);
      for (int i = 0; i < 9; i++) rd_chk("reset word", 6'(i * 4), WORD_ZERO);
      end_test("reset");
      foreach (pat[i]) begin
         wr_reg(OFS_SERIAL, {24'h0, pat[i]});
         op(OPC_LOAD_SERIAL_PAIR);
         chk("acc", 32'(pat[i][3:0]), 32'(acc_o));
         chk("reg b", 32'(pat[i][7:4]), 32'(reg_b_o));
         rd_chk("serial", OFS_SERIAL, {24'h0, pat[i]});
      end
      end_test("serial pair");
      for (int p = 0; p < 8; p++) begin
         wr_reg(OFS_ACC, 32'h0000_000F);
         wr_reg(OFS_STATUS, 32'h0000_0001);
         wr_reg(OFS_POINTER, 32'(p));
         op(OPC_LOAD_POINTER);
         chk("acc", 32'(p), 32'(acc_o));
         rd_chk("status", OFS_STATUS, 32'h0000_0001);
         rd_chk("pointer", OFS_POINTER, 32'(p));
      end
      end_test("pointer");
      wr_reg(OFS_CONV, 32'h0000_0007);
      wr_reg(OFS_ACC, 32'h0000_0003);
      wr_reg(OFS_REG_B, 32'h0000_000C);
      op(OPC_LOAD_COMPARE_VALUE);
      chk("compare", 32'h0000_0000, 32'(compare_o));
      chk("acc", 32'h0000_0003, 32'(acc_o));
      chk("reg b", 32'h0000_000C, 32'(reg_b_o));
      wr_reg(OFS_CONV, 32'h0000_0008);
      op(OPC_LOAD_COMPARE_VALUE);
      chk("compare", 32'h0000_00C3, 32'(compare_o));
      wr_reg(OFS_CONV, 32'h0000_000F);
      wr_reg(OFS_ACC, 32'h0000_000A);
      wr_reg(OFS_REG_B, 32'h0000_0005);
      op(OPC_LOAD_COMPARE_VALUE);
      rd_chk("compare", OFS_CMP, 32'h0000_005A);
      chk("reg b", 32'h0000_0005, 32'(reg_b_o));
      wr_reg(OFS_CONV, 32'h0000_0000);
      wr_reg(OFS_ACC, 32'h0000_0000);
      op(OPC_LOAD_COMPARE_VALUE);
      chk("compare", 32'h0000_005A, 32'(compare_o));
      end_test("compare");
      wr_reg(OFS_STATUS, 32'h0000_0001);
      wr_reg(OFS_IRQ1, 32'h0000_0009);
      op(OPC_READ_IRQ_CTRL_ONE);
      chk("acc", 32'h0000_0009, 32'(acc_o));
      rd_chk("irq ctrl", OFS_IRQ1, 32'h0000_0009);
      rd_chk("status", OFS_STATUS, 32'h0000_0001);
      end_test("irq read");
      // Refused accesses leave state unchanged; an unknown opcode pulses exec and sets only the status unknown bit and the last opcode
      rd_chk("unmapped", 6'h24, 32'h0000_0000);
      wr_reg(OFS_CMP, 32'h0000_00FF);
      rd_chk("compare", OFS_CMP, 32'h0000_005A);
      wr_reg(OFS_SERIAL, 32'h0000_0012);
      wr_reg(OFS_INSTR, 32'h0000_0278, 4'h1);
      chk_bit("exec pulse", 1'b0, ex_q);
      chk("acc", 32'h0000_0009, 32'(acc_o));
      wr_reg(OFS_INSTR, 32'h0000_03FF);
      chk_bit("exec pulse", 1'b1, ex_q);
      rd_chk("status", OFS_STATUS, 32'h0000_0005);
      rd_chk("last opcode", OFS_INSTR, 32'h0000_03FF);
      chk("reg b", 32'h0000_0005, 32'(reg_b_o));
      end_test("refused");
      print_verdict();
   end

endmodule // rti_exec_tb_top

`default_nettype wire

/* src/rti_exec.sv */
// Transfer instruction executor with an Avalon-MM register slave
//
// Notes on behaviour
// - Serial opcode: high nibble to B, low to A
// - Pointer opcode: pointer into A[2:0], carry kept
// - Pointer opcode always clears accumulator bit 3
// - Compare opcode in conversion mode does nothing
// - Compare opcode in comparator mode writes {B,A}
// - Irq opcode: irq control one into A
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module rti_exec
   import rti_pkg::*;
(
   input wire logic clock_i,                 // 200 MHz core clock
   input wire logic arst_n_i,                // Asynchronous reset, active low
   input wire logic [ADDR_W-1:0] avs_address_i, // Byte address
   input wire logic avs_read_i,              // Read request
   input wire logic avs_write_i,             // Write request
   input wire logic [DATA_W-1:0] avs_writedata_i, // Write data
   input wire logic [3:0] avs_byteenable_i,  // Byte lanes
   output logic [DATA_W-1:0] avs_readdata_o, // Read data
   output logic avs_waitrequest_o,           // Stall while high
   output logic [3:0] acc_o,                 // Accumulator
   output logic [3:0] reg_b_o,               // Upper holding register
   output logic [7:0] compare_o,             // Comparator value
   output logic exec_o                       // Pulse after an opcode runs
);

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Bus handshake: a request is taken while waitrequest is high,
   // then waitrequest drops for exactly one cycle to complete it
   logic wait_q, wait_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic take_wr, take_rd;

   // State of the core
   logic [3:0] acc_q, acc_d;
   logic [3:0] reg_b_q, reg_b_d;
   logic [7:0] serial_q, serial_d;
   logic [2:0] pointer_q, pointer_d;
   logic [3:0] conv_q, conv_d;
   logic [3:0] irq1_q, irq1_d;
   logic [7:0] cmp_q, cmp_d;
   logic carry_q, carry_d;
   logic unknown_q, unknown_d;
   logic [9:0] last_op_q, last_op_d;
   logic exec_q, exec_d;
   logic issue;
   rti_op_t op;

   assign take_wr = avs_write_i & wait_q;
   assign take_rd = avs_read_i & wait_q;
   assign issue = take_wr & (avs_address_i == OFS_INSTR) & (&avs_byteenable_i[1:0]);
   assign op = rti_decode(avs_writedata_i[9:0]);

   // Read data mux, unmapped addresses read as zero
   always_comb begin
      wait_d = 1'b1;
      rdata_d = rdata_q;
      if (take_wr | take_rd) begin
         wait_d = 1'b0;
      end
      if (take_rd) begin
         rdata_d = WORD_ZERO;
         unique case (avs_address_i)
            OFS_INSTR: rdata_d[9:0] = last_op_q;
            OFS_ACC: rdata_d[3:0] = acc_q;
            OFS_REG_B: rdata_d[3:0] = reg_b_q;
            OFS_SERIAL: rdata_d[7:0] = serial_q;
            OFS_POINTER: rdata_d[2:0] = pointer_q;
            OFS_CONV: rdata_d[3:0] = conv_q;
            OFS_IRQ1: rdata_d[3:0] = irq1_q;
            OFS_CMP: rdata_d[7:0] = cmp_q;
            OFS_STATUS: begin
               rdata_d[STATUS_CARRY_BIT] = carry_q;
               rdata_d[STATUS_UNKNOWN_BIT] = unknown_q;
            end
            default: rdata_d = WORD_ZERO;
         endcase
      end
   end

   // Handshake and read data registers
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         wait_q <= 1'b1;
         rdata_q <= WORD_ZERO;
      end else begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes and instruction execution
   always_comb begin
      acc_d = acc_q;
      reg_b_d = reg_b_q;
      serial_d = serial_q;
      pointer_d = pointer_q;
      conv_d = conv_q;
      irq1_d = irq1_q;
      cmp_d = cmp_q;
      carry_d = carry_q;
      unknown_d = unknown_q;
      last_op_d = last_op_q;
      exec_d = 1'b0;
      if (issue) begin
         last_op_d = avs_writedata_i[9:0];
         exec_d = 1'b1;
         unknown_d = (op == OP_NONE);
         // Sources and carry are never written below
         // sources left alone
         unique case (op)
            OP_LOAD_SERIAL_PAIR: begin
               reg_b_d = serial_q[7:4];
               acc_d = serial_q[3:0];
            end
            OP_LOAD_POINTER: begin
               acc_d[2:0] = pointer_q;
               acc_d[3] = 1'b0;
            end
            OP_LOAD_COMPARE_VALUE: begin
               if (conv_q[CONVERTER_MODE_BIT]) begin
                  cmp_d = {reg_b_q, acc_q};
               end
            end
            OP_READ_IRQ_CTRL_ONE: begin
               acc_d = irq1_q;
            end
            OP_NONE: begin
               acc_d = acc_q;
            end
         endcase
      end else if (take_wr & avs_byteenable_i[0]) begin
         unique case (avs_address_i)
            OFS_ACC: acc_d = avs_writedata_i[3:0];
            OFS_REG_B: reg_b_d = avs_writedata_i[3:0];
            OFS_SERIAL: serial_d = avs_writedata_i[7:0];
            OFS_POINTER: pointer_d = avs_writedata_i[2:0];
            OFS_CONV: conv_d = avs_writedata_i[3:0];
            OFS_IRQ1: irq1_d = avs_writedata_i[3:0];
            OFS_STATUS: carry_d = avs_writedata_i[STATUS_CARRY_BIT];
            default: acc_d = acc_q;
         endcase
      end
   end

   // Core registers
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= NIBBLE_RST;
         reg_b_q <= NIBBLE_RST;
         serial_q <= BYTE_RST;
         pointer_q <= POINTER_RST;
         conv_q <= NIBBLE_RST;
         irq1_q <= NIBBLE_RST;
         cmp_q <= BYTE_RST;
         carry_q <= 1'b0;
         unknown_q <= 1'b0;
         last_op_q <= OPCODE_RST;
         exec_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         reg_b_q <= reg_b_d;
         serial_q <= serial_d;
         pointer_q <= pointer_d;
         conv_q <= conv_d;
         irq1_q <= irq1_d;
         cmp_q <= cmp_d;
         carry_q <= carry_d;
         unknown_q <= unknown_d;
         last_op_q <= last_op_d;
         exec_q <= exec_d;
      end
   end

   // Outputs straight from flip-flops
   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign acc_o = acc_q;
   assign reg_b_o = reg_b_q;
   assign compare_o = cmp_q;
   assign exec_o = exec_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_issue(rti_op_t kind);
      issue && (op == kind);
   endsequence

   sequence s_cmp_write;
      s_issue(OP_LOAD_COMPARE_VALUE) ##0 conv_q[CONVERTER_MODE_BIT];
   endsequence

   serial_split_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      s_issue(OP_LOAD_SERIAL_PAIR) |=> ({reg_b_q, acc_q} == $past(serial_q)) && exec_q)
      else $error("serial pair not split into B and A");

   pointer_copy_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      s_issue(OP_LOAD_POINTER) |=> (acc_q[2:0] == $past(pointer_q)) && $stable(carry_q))
      else $error("pointer not copied or carry changed");

   acc_top_zero_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      s_issue(OP_LOAD_POINTER) |=> (acc_q[3] == 1'b0) [*2])
      else $error("accumulator bit 3 not cleared");

   cmp_nop_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      s_issue(OP_LOAD_COMPARE_VALUE) ##0 !conv_q[CONVERTER_MODE_BIT]
      |=> $stable(cmp_q) && $stable(acc_q) && $stable(reg_b_q) && $stable(carry_q))
      else $error("compare opcode changed state in conversion mode");

   cmp_write_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      s_cmp_write |=> (cmp_q == {$past(reg_b_q), $past(acc_q)}) && (compare_o == cmp_q))
      else $error("comparator value not written from B and A");

   cmp_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      !$stable(cmp_q) |-> $past(issue) && $past(op == OP_LOAD_COMPARE_VALUE)
      && $past(conv_q[CONVERTER_MODE_BIT]))
      else $error("comparator changed without comparator mode");

   irq_read_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      s_issue(OP_READ_IRQ_CTRL_ONE) |=> (acc_q == $past(irq1_q)) && $stable(carry_q))
      else $error("interrupt control not loaded into accumulator");

   src_keep_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      issue |=> $stable(serial_q) && $stable(pointer_q) && $stable(irq1_q) && $stable(conv_q))
      else $error("source register changed by an instruction");

   // Bus answers one cycle after a request is taken
   bus_answer_a: assert property (@(posedge clock_i) disable iff (!rst_n)
      (avs_read_i || avs_write_i) && wait_q |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("waitrequest did not drop for exactly one cycle");

endmodule // rti_exec

`default_nettype wire
